// ---- acmp_defs.vh ----
// constants for the dual comparator control block: register offsets,
// field positions, reset values and widths
// assumes inclusion by the comparator design, checker and bench files
`ifndef ACMP_DEFS_VH
`define ACMP_DEFS_VH

// ***************************************************************
// register offsets
// ***************************************************************
`define ACMP_ADDR_W 4
`define ACMP_OFS_CTL_A 4'h0
`define ACMP_OFS_MODE_A 4'h1
`define ACMP_OFS_CTL_B 4'h2
`define ACMP_OFS_MODE_B 4'h3
`define ACMP_OFS_STATUS 4'h4
`define ACMP_OFS_CLEAR 4'h5
`define ACMP_OFS_IRQ_EN 4'h6

// ***************************************************************
// control register fields
// ***************************************************************
`define ACMP_CTL_EN_BIT 7
`define ACMP_CTL_OUT_BIT 6
`define ACMP_CTL_RISE_BIT 5
`define ACMP_CTL_FALL_BIT 4
`define ACMP_CTL_HYP_HI 3
`define ACMP_CTL_HYP_LO 2
`define ACMP_CTL_HYN_HI 1
`define ACMP_CTL_HYN_LO 0

// ***************************************************************
// mode register fields
// ***************************************************************
`define ACMP_MODE_RSVD_BIT 7
`define ACMP_MODE_RIE_BIT 5
`define ACMP_MODE_FIE_BIT 4
`define ACMP_MODE_MD_HI 1
`define ACMP_MODE_MD_LO 0

// ***************************************************************
// status, clear and interrupt enable fields
// ***************************************************************
`define ACMP_STAT_RISE_A_BIT 0
`define ACMP_STAT_FALL_A_BIT 1
`define ACMP_STAT_RISE_B_BIT 2
`define ACMP_STAT_FALL_B_BIT 3
`define ACMP_IEN_SRC_A_BIT 0
`define ACMP_IEN_SRC_B_BIT 1
`define ACMP_IEN_GLOBAL_BIT 7

// ***************************************************************
// reset values and encodings
// ***************************************************************
`define ACMP_RST_EN 1'b0
`define ACMP_RST_HYS 2'h0
`define ACMP_RST_EDGE_EN 1'b0
`define ACMP_RST_MD 2'h2
`define ACMP_RST_IEN 8'h00
`define ACMP_HYS_OFF 2'h0
`define ACMP_HYS_5MV 2'h1
`define ACMP_HYS_10MV 2'h2
`define ACMP_HYS_20MV 2'h3
`define ACMP_MD_FASTEST 2'h0
`define ACMP_MD_LOWEST_PWR 2'h3
`define ACMP_SYNC_RST 1'b0

`endif

// ---- acmp_sync2.v ----
// two flip-flop synchroniser for a bus of independent level signals
// assumes each bit is a level that stays put for several clock periods
`timescale 1ns/1ps
`default_nettype none
`include "acmp_defs.vh"

module acmp_sync2 #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // levels
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= {WIDTH{`ACMP_SYNC_RST}};
            sync_r <= {WIDTH{`ACMP_SYNC_RST}};
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;

endmodule
`default_nettype wire

// ---- acmp_edge_flags.v ----
// per comparator edge detector with sticky rising and falling flags
// assumes the input is already synchronised to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "acmp_defs.vh"

module acmp_edge_flags (
    // clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // synchronised comparator level
    input wire level_i,
    // software clears, one cycle each
    input wire clr_rise_i,
    input wire clr_fall_i,
    // state
    output wire latched_o,
    output wire rise_flag_o,
    output wire fall_flag_o
);

    reg prev_r;
    reg rise_r;
    reg fall_r;
    wire rise_evt;
    wire fall_evt;

    // current sample against the previous one, one event per transition
    assign rise_evt = level_i & ~prev_r;
    assign fall_evt = ~level_i & prev_r;

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end else begin
            prev_r <= level_i;
            // set wins over a clear in the same cycle; only software clears
            rise_r <= rise_evt | (rise_r & ~clr_rise_i);
            fall_r <= fall_evt | (fall_r & ~clr_fall_i);
        end
    end

    assign latched_o = prev_r;
    assign rise_flag_o = rise_r;
    assign fall_flag_o = fall_r;

endmodule
`default_nettype wire

// ---- analog_comparator_edge_logic.v ----
// digital control around two identical analog voltage comparators
// assumes the analog cores report their decision as a level on
// cmp_decision_i and take enable, response mode and hysteresis settings
// from this block; the raw path does not need the clock
//
// What this block does
// - enabled comparator outputs high when positive input exceeds negative input.
// - a disabled comparator's output is forced low.
// - output is synchronised to the system clock, readable, interrupt source, pin.
// - an unsynchronised raw output feeds wake-up, reset and pins without clock.
// - rising and falling flags set on every edge of the gated output, regardless of interrupt enables.
// - edge flags stay set until software clears them.
// - separate rising and falling interrupt enables in each mode register.
// - interrupt needs edge enable, comparator source enable and global enable.
// - four response time modes per comparator, fastest to lowest power.
// - a disabled comparator is placed in low power shutdown.
// - positive hysteresis delays the rise by the programmed amount.
// - negative hysteresis delays the fall by the programmed amount.
// - separate control fields select 20, 10, 5 or 0 mV hysteresis.
// - both comparators share identical control, flag and output behaviour.
// - no comparisons until enable written high; enable low disables it.
// - negative hysteresis code 00 off, 01 5mV, 10 10mV, 11 20mV.
// - response mode code 00 fastest, through 11 slowest and lowest power.
`timescale 1ns/1ps
`default_nettype none
`include "acmp_defs.vh"

module analog_comparator_edge_logic #(
    parameter NUM_CMP = 2,
    parameter DATA_W = 8
) (
    // clock and reset
    input wire clk_sys_i,
    input wire arst_n_i,
    // register port
    input wire [`ACMP_ADDR_W-1:0] reg_addr_i,
    input wire [DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [DATA_W-1:0] reg_rdata_o,
    // analog core decisions, index 0 is comparator_a, index 1 comparator_b
    input wire [NUM_CMP-1:0] cmp_decision_i,
    // analog core settings
    output wire [NUM_CMP-1:0] comparator_enable_o,
    output wire [NUM_CMP-1:0] shutdown_o,
    output wire [2*NUM_CMP-1:0] response_mode_o,
    output wire [2*NUM_CMP-1:0] pos_hysteresis_sel_o,
    output wire [2*NUM_CMP-1:0] neg_hysteresis_sel_o,
    // comparator outputs
    output wire latched_output_a_o,
    output wire latched_output_b_o,
    output wire raw_output_a_o,
    output wire raw_output_b_o,
    // interrupt
    output wire irq_o
);

    // ***************************************************************
    // register state
    // ***************************************************************
    reg [NUM_CMP-1:0] en_r;
    reg [NUM_CMP-1:0] shutdown_r;
    reg [2*NUM_CMP-1:0] pos_hys_r;
    reg [2*NUM_CMP-1:0] neg_hys_r;
    reg [2*NUM_CMP-1:0] mode_r;
    reg [NUM_CMP-1:0] rise_ie_r;
    reg [NUM_CMP-1:0] fall_ie_r;
    reg [DATA_W-1:0] irq_en_r;
    reg [DATA_W-1:0] rdata_r;
    reg [DATA_W-1:0] rdata_nxt;
    reg irq_r;
    reg irq_nxt;

    wire [NUM_CMP-1:0] raw_gated;
    wire [NUM_CMP-1:0] sync_level;
    wire [NUM_CMP-1:0] latched;
    wire [NUM_CMP-1:0] rise_flag;
    wire [NUM_CMP-1:0] fall_flag;
    wire [NUM_CMP-1:0] clr_rise;
    wire [NUM_CMP-1:0] clr_fall;
    wire [NUM_CMP-1:0] src_en;
    wire clear_wr;

    // ***************************************************************
    // raw path
    // ***************************************************************
    // combinational on purpose: it must stay valid with the clock stopped
    assign raw_gated = cmp_decision_i & en_r;
    assign raw_output_a_o = raw_gated[0];
    assign raw_output_b_o = raw_gated[1];

    // ***************************************************************
    // synchronised path
    // ***************************************************************
    acmp_sync2 #(
        .WIDTH(NUM_CMP)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i(raw_gated),
        .sync_o(sync_level)
    );

    assign clear_wr = reg_wr_i && (reg_addr_i == `ACMP_OFS_CLEAR);
    assign src_en[0] = irq_en_r[`ACMP_IEN_SRC_A_BIT];
    assign src_en[1] = irq_en_r[`ACMP_IEN_SRC_B_BIT];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CMP; ch = ch + 1) begin : g_cmp
            wire ctl_wr;
            wire mode_wr;

            assign ctl_wr = reg_wr_i && (reg_addr_i == `ACMP_OFS_CTL_A + 2 * ch);
            assign mode_wr = reg_wr_i && (reg_addr_i == `ACMP_OFS_MODE_A + 2 * ch);

            // flags clear by writing 0 to them in control, or 1 in clear
            assign clr_rise[ch] = (ctl_wr && !reg_wdata_i[`ACMP_CTL_RISE_BIT]) ||
                (clear_wr && reg_wdata_i[`ACMP_STAT_RISE_A_BIT + 2 * ch]);
            assign clr_fall[ch] = (ctl_wr && !reg_wdata_i[`ACMP_CTL_FALL_BIT]) ||
                (clear_wr && reg_wdata_i[`ACMP_STAT_FALL_A_BIT + 2 * ch]);

            // identical logic for both comparators
            acmp_edge_flags u_edge (
                .clk_sys_i(clk_sys_i),
                .arst_n_i(arst_n_i),
                .level_i(sync_level[ch]),
                .clr_rise_i(clr_rise[ch]),
                .clr_fall_i(clr_fall[ch]),
                .latched_o(latched[ch]),
                .rise_flag_o(rise_flag[ch]),
                .fall_flag_o(fall_flag[ch])
            );

            always @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    en_r[ch] <= `ACMP_RST_EN;
                    shutdown_r[ch] <= ~`ACMP_RST_EN;
                    pos_hys_r[2*ch+1:2*ch] <= `ACMP_RST_HYS;
                    neg_hys_r[2*ch+1:2*ch] <= `ACMP_RST_HYS;
                    mode_r[2*ch+1:2*ch] <= `ACMP_RST_MD;
                    rise_ie_r[ch] <= `ACMP_RST_EDGE_EN;
                    fall_ie_r[ch] <= `ACMP_RST_EDGE_EN;
                end else begin
                    if (ctl_wr) begin
                        en_r[ch] <= reg_wdata_i[`ACMP_CTL_EN_BIT];
                        // own flop so the core's power request never glitches
                        shutdown_r[ch] <= ~reg_wdata_i[`ACMP_CTL_EN_BIT];
                        pos_hys_r[2*ch+1:2*ch] <=
                            reg_wdata_i[`ACMP_CTL_HYP_HI:`ACMP_CTL_HYP_LO];
                        neg_hys_r[2*ch+1:2*ch] <=
                            reg_wdata_i[`ACMP_CTL_HYN_HI:`ACMP_CTL_HYN_LO];
                    end
                    if (mode_wr) begin
                        rise_ie_r[ch] <= reg_wdata_i[`ACMP_MODE_RIE_BIT];
                        fall_ie_r[ch] <= reg_wdata_i[`ACMP_MODE_FIE_BIT];
                        mode_r[2*ch+1:2*ch] <=
                            reg_wdata_i[`ACMP_MODE_MD_HI:`ACMP_MODE_MD_LO];
                    end
                end
            end
        end
    endgenerate

    // ***************************************************************
    // analog core settings
    // ***************************************************************
    // codes pass unchanged: the core maps 00..11 to off/5/10/20 mV and to
    // fastest..lowest power, and applies the thresholds to its decision
    assign comparator_enable_o = en_r;
    assign shutdown_o = shutdown_r;
    assign response_mode_o = mode_r;
    assign pos_hysteresis_sel_o = pos_hys_r;
    assign neg_hysteresis_sel_o = neg_hys_r;

    assign latched_output_a_o = latched[0];
    assign latched_output_b_o = latched[1];

    // ***************************************************************
    // interrupt enable register and request
    // ***************************************************************
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_en_r <= `ACMP_RST_IEN;
        end else if (reg_wr_i && (reg_addr_i == `ACMP_OFS_IRQ_EN)) begin
            irq_en_r <= reg_wdata_i;
        end
    end

    always @* begin
        irq_nxt = irq_en_r[`ACMP_IEN_GLOBAL_BIT] &
            (|(((rise_flag & rise_ie_r) | (fall_flag & fall_ie_r)) & src_en));
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign irq_o = irq_r;

    // ***************************************************************
    // read data, one cycle after the read strobe
    // ***************************************************************
    always @* begin
        rdata_nxt = {DATA_W{1'b0}};
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ACMP_OFS_CTL_A, `ACMP_OFS_CTL_B: begin
                    rdata_nxt[`ACMP_CTL_EN_BIT] = en_r[reg_addr_i[1]];
                    rdata_nxt[`ACMP_CTL_OUT_BIT] = latched[reg_addr_i[1]];
                    rdata_nxt[`ACMP_CTL_RISE_BIT] = rise_flag[reg_addr_i[1]];
                    rdata_nxt[`ACMP_CTL_FALL_BIT] = fall_flag[reg_addr_i[1]];
                    rdata_nxt[`ACMP_CTL_HYP_HI:`ACMP_CTL_HYP_LO] =
                        pos_hys_r[2*reg_addr_i[1] +: 2];
                    rdata_nxt[`ACMP_CTL_HYN_HI:`ACMP_CTL_HYN_LO] =
                        neg_hys_r[2*reg_addr_i[1] +: 2];
                end
                `ACMP_OFS_MODE_A, `ACMP_OFS_MODE_B: begin
                    rdata_nxt[`ACMP_MODE_RSVD_BIT] = 1'b1;
                    rdata_nxt[`ACMP_MODE_RIE_BIT] = rise_ie_r[reg_addr_i[1]];
                    rdata_nxt[`ACMP_MODE_FIE_BIT] = fall_ie_r[reg_addr_i[1]];
                    rdata_nxt[`ACMP_MODE_MD_HI:`ACMP_MODE_MD_LO] =
                        mode_r[2*reg_addr_i[1] +: 2];
                end
                `ACMP_OFS_STATUS: begin
                    rdata_nxt[`ACMP_STAT_RISE_A_BIT] = rise_flag[0];
                    rdata_nxt[`ACMP_STAT_FALL_A_BIT] = fall_flag[0];
                    rdata_nxt[`ACMP_STAT_RISE_B_BIT] = rise_flag[1];
                    rdata_nxt[`ACMP_STAT_FALL_B_BIT] = fall_flag[1];
                end
                `ACMP_OFS_IRQ_EN: begin
                    rdata_nxt = irq_en_r;
                end
                default: begin
                    rdata_nxt = {DATA_W{1'b0}};
                end
            endcase
        end
    end

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= {DATA_W{1'b0}};
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

endmodule
`default_nettype wire

// ---- acmp_checker_asserts.sv ----
// port level checks for the dual comparator block
// assumes the register map of acmp_defs.vh and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "acmp_defs.vh"
module acmp_checker #(
    parameter NUM_CMP = 2,
    parameter DATA_W = 8
) (
    // clock, reset, register port
    input wire clk_sys_i,
    input wire arst_n_i,
    input wire [`ACMP_ADDR_W-1:0] reg_addr_i,
    input wire [DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [DATA_W-1:0] reg_rdata_o,
    // comparator side
    input wire [NUM_CMP-1:0] cmp_decision_i,
    input wire [NUM_CMP-1:0] comparator_enable_o,
    input wire [NUM_CMP-1:0] shutdown_o,
    input wire [2*NUM_CMP-1:0] response_mode_o,
    input wire [2*NUM_CMP-1:0] pos_hysteresis_sel_o,
    input wire [2*NUM_CMP-1:0] neg_hysteresis_sel_o,
    input wire latched_output_a_o,
    input wire latched_output_b_o,
    input wire raw_output_a_o,
    input wire raw_output_b_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    shutdown_follow_a: assert property (shutdown_o == ~comparator_enable_o)
        else $error("shutdown differs from enable");
    raw_gate_a_a: assert property (raw_output_a_o == (cmp_decision_i[0] & comparator_enable_o[0]))
        else $error("raw output a wrong");
    raw_gate_b_a: assert property (raw_output_b_o == (cmp_decision_i[1] & comparator_enable_o[1]))
        else $error("raw output b wrong");
    latch_delay_a_a: assert property (latched_output_a_o == $past(raw_output_a_o, 3))
        else $error("latched output a not three edges behind raw");
    latch_delay_b_a: assert property (latched_output_b_o == $past(raw_output_b_o, 3))
        else $error("latched output b not three edges behind raw");
    mode_write_a: assert property (reg_wr_i && reg_addr_i == `ACMP_OFS_MODE_A |=>
        response_mode_o[1:0] == $past(reg_wdata_i[1:0])) else $error("mode a not taken");
    mode_hold_a: assert property (!reg_wr_i |=> $stable(response_mode_o))
        else $error("mode changed without write");
    ctl_write_a: assert property (reg_wr_i && reg_addr_i == `ACMP_OFS_CTL_B |=>
        comparator_enable_o[1] == $past(reg_wdata_i[7]) &&
        pos_hysteresis_sel_o[3:2] == $past(reg_wdata_i[3:2]) &&
        neg_hysteresis_sel_o[3:2] == $past(reg_wdata_i[1:0])) else $error("ctl b not taken");
    out_bit_read_a: assert property (reg_rd_i && reg_addr_i == `ACMP_OFS_CTL_A |=>
        reg_rdata_o[6] == $past(latched_output_a_o)) else $error("output bit read wrong");
endmodule
bind analog_comparator_edge_logic acmp_checker #(.NUM_CMP(NUM_CMP), .DATA_W(DATA_W))
    acmp_checker_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cmp_decision_i(cmp_decision_i),
    .comparator_enable_o(comparator_enable_o), .shutdown_o(shutdown_o),
    .response_mode_o(response_mode_o), .pos_hysteresis_sel_o(pos_hysteresis_sel_o),
    .neg_hysteresis_sel_o(neg_hysteresis_sel_o), .latched_output_a_o(latched_output_a_o),
    .latched_output_b_o(latched_output_b_o), .raw_output_a_o(raw_output_a_o),
    .raw_output_b_o(raw_output_b_o));
`default_nettype wire

// ---- analog_core_model.sv ----
// behavioural model of the two analog comparator cores
// assumes millivolt inputs in 16 bit slices, index 0 is comparator a
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
    // settings from the block
    input wire logic [1:0] enable_i,
    input wire logic [3:0] pos_hys_i,
    input wire logic [3:0] neg_hys_i,
    // input voltages
    input wire logic [31:0] pos_mv_i,
    input wire logic [31:0] neg_mv_i,
    output var logic [1:0] decision_o
);
    integer i;
    integer p;
    integer n;
    function automatic integer hys_mv(input logic [1:0] c);
        hys_mv = (c == 2'h3) ? 20 : (c == 2'h2) ? 10 : (c == 2'h1) ? 5 : 0;
    endfunction
    initial decision_o = 2'b00;
    // a powered down core keeps comparing; gating is the block's job
    always @(enable_i, pos_hys_i, neg_hys_i, pos_mv_i, neg_mv_i) begin
        for (i = 0; i < 2; i = i + 1) begin
            p = pos_mv_i[16*i +: 16];
            n = neg_mv_i[16*i +: 16];
            if (!decision_o[i] && p > n + hys_mv(pos_hys_i[2*i +: 2])) begin
                decision_o[i] = 1'b1;
            end else if (decision_o[i] && p < n - hys_mv(neg_hys_i[2*i +: 2])) begin
                decision_o[i] = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- analog_comparator_edge_logic_bench.sv ----
// self-checking bench for the dual comparator block
// assumes the register map of acmp_defs.vh and the analog core model
`timescale 1ns/1ps
`default_nettype none
`include "acmp_defs.vh"
module analog_comparator_edge_logic_bench;
    logic clk_sys_i;
    logic arst_n_i;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic [1:0] cmp_decision_i;
    logic [1:0] comparator_enable_o;
    logic [1:0] shutdown_o;
    logic [3:0] response_mode_o;
    logic [3:0] pos_hys;
    logic [3:0] neg_hys;
    logic [1:0] lat;
    logic [1:0] raw;
    logic irq_o;
    logic [31:0] pos_mv;
    logic [31:0] neg_mv;
    integer failures;
    integer total_checks;
    analog_comparator_edge_logic analog_comparator_edge_logic_inst (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .cmp_decision_i(cmp_decision_i), .comparator_enable_o(comparator_enable_o),
        .shutdown_o(shutdown_o), .response_mode_o(response_mode_o),
        .pos_hysteresis_sel_o(pos_hys), .neg_hysteresis_sel_o(neg_hys),
        .latched_output_a_o(lat[0]), .latched_output_b_o(lat[1]), .raw_output_a_o(raw[0]),
        .raw_output_b_o(raw[1]), .irq_o(irq_o));
    analog_core_model analog_core_model_inst (.enable_i(comparator_enable_o),
        .pos_hys_i(pos_hys), .neg_hys_i(neg_hys), .pos_mv_i(pos_mv), .neg_mv_i(neg_mv),
        .decision_o(cmp_decision_i));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("read data", e, reg_rdata_o);
    endtask
    task automatic idle(input integer n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic set_pos(input integer c, input logic [15:0] v);
        @(posedge clk_sys_i);
        pos_mv[16*c +: 16] <= v;
    endtask
    task automatic t_reset;
        logic [7:0] exp [0:7];
        integer k;
        exp = '{8'h00, 8'h82, 8'h00, 8'h82, 8'h00, 8'h00, 8'h00, 8'h00};
        chk("shutdown", 8'h03, {6'h0, shutdown_o});
        chk("response mode", 8'h0a, {4'h0, response_mode_o});
        for (k = 0; k < 7; k = k + 1) rdc(k[3:0], exp[k]);
        rdc(4'hf, exp[7]);
    endtask
    task automatic t_disabled;
        set_pos(0, 16'd500);
        set_pos(1, 16'd500);
        idle(6);
        chk("raw outputs", 8'h00, {6'h0, raw});
        chk("latched outputs", 8'h00, {6'h0, lat});
        rdc(`ACMP_OFS_STATUS, 8'h00);
    endtask
    task automatic t_edges(input integer c);
        logic [3:0] ctl;
        logic [7:0] rb;
        ctl = c * 2;
        rb = 8'h01 << (2 * c);
        set_pos(c, 16'd100);
        idle(6);
        wr(ctl, 8'hb0);
        idle(6);
        wr(`ACMP_OFS_CLEAR, 8'h0f);
        rdc(`ACMP_OFS_STATUS, 8'h00);
        set_pos(c, 16'd300);
        idle(6);
        chk("latched high", 8'h01, {7'h0, lat[c]});
        rdc(`ACMP_OFS_STATUS, rb);
        set_pos(c, 16'd100);
        idle(26);
        chk("latched low", 8'h00, {7'h0, lat[c]});
        rdc(`ACMP_OFS_STATUS, rb * 3);
        wr(ctl, 8'h90);
        rdc(`ACMP_OFS_STATUS, rb * 2);
        wr(`ACMP_OFS_CLEAR, 8'h0f);
        rdc(`ACMP_OFS_STATUS, 8'h00);
    endtask
    task automatic t_irq;
        wr(`ACMP_OFS_MODE_A, 8'ha2);
        wr(`ACMP_OFS_IRQ_EN, 8'h01);
        set_pos(0, 16'd300);
        idle(6);
        chk("irq no global", 8'h00, {7'h0, irq_o});
        wr(`ACMP_OFS_IRQ_EN, 8'h81);
        idle(2);
        chk("irq all set", 8'h01, {7'h0, irq_o});
        wr(`ACMP_OFS_IRQ_EN, 8'h82);
        idle(2);
        chk("irq no source", 8'h00, {7'h0, irq_o});
        wr(`ACMP_OFS_IRQ_EN, 8'h83);
        wr(`ACMP_OFS_MODE_A, 8'h92);
        idle(2);
        chk("irq other edge", 8'h00, {7'h0, irq_o});
        wr(`ACMP_OFS_MODE_A, 8'hb2);
        idle(2);
        chk("irq edge on", 8'h01, {7'h0, irq_o});
        wr(`ACMP_OFS_CLEAR, 8'h01);
        idle(2);
        chk("irq cleared", 8'h00, {7'h0, irq_o});
        rdc(`ACMP_OFS_IRQ_EN, 8'h83);
    endtask
    task automatic t_disable_fall;
        wr(`ACMP_OFS_CTL_A, 8'h30);
        idle(6);
        chk("latched off", 8'h00, {7'h0, lat[0]});
        chk("shutdown a", 8'h01, {7'h0, shutdown_o[0]});
        rdc(`ACMP_OFS_STATUS, 8'h02);
    endtask
    task automatic t_codes;
        integer k;
        for (k = 0; k < 4; k = k + 1) begin
            wr(`ACMP_OFS_MODE_B, 8'h80 | k[7:0]);
            wr(`ACMP_OFS_CTL_B, {4'h0, k[1:0], k[1:0]});
            #1;
            chk("mode b", k[7:0], {6'h0, response_mode_o[3:2]});
            chk("pos hys b", k[7:0], {6'h0, pos_hys[3:2]});
            chk("neg hys b", k[7:0], {6'h0, neg_hys[3:2]});
            rdc(`ACMP_OFS_MODE_B, 8'h80 | k[7:0]);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #100000;
        failures = failures + 1;
        tally_and_finish;
    end
    initial begin
        failures = 0;
        total_checks = 0;
        arst_n_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        pos_mv = 32'h0;
        neg_mv = {16'd200, 16'd200};
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_reset;
        t_disabled;
        t_edges(0);
        t_edges(1);
        t_irq;
        t_disable_fall;
        t_codes;
        tally_and_finish;
    end
endmodule
`default_nettype wire
